// ===== sbpm_mux.sv
// Pin function selection, general input reporting and strap capture
`timescale 1ns/1ps
module sbpm_mux (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Configuration and software controls
  input wire sbpm_pkg::sbpm_cfg_t cfg_i,
  input wire logic [31:0] gpo_state_i,
  input wire logic pci_reset_req_i,
  input wire logic [7:0] chg_route_smi_i,
  input wire logic [7:0] chg_clr_i,
  // Internal controllers
  input wire logic ptr_clk_drv_i,
  input wire logic ptr_data_drv_i,
  input wire logic kp_clk_drv_i,
  input wire logic kp_data_drv_i,
  input wire logic ext_kbc_select_n_i,
  input wire logic speaker_i,
  input wire logic [1:0] pcs_n_i,
  input wire logic smb2_data_drv_i,
  input wire logic smb2_clk_drv_i,
  // Pin levels
  input wire logic [6:0] general_input_i,
  input wire logic [1:0] general_input_hi_i,
  input wire logic [2:0] general_input_aux_i,
  input wire logic sixth_bus_request_n_i,
  input wire logic [3:0] extra_pci_interrupt_n_i,
  input wire logic thermal_alarm_n_i,
  input wire logic [1:0] audio_serial_in_i,
  input wire logic [3:0] od_pin_i,
  input wire logic second_smbus_data_pin_i,
  input wire logic second_smbus_clock_pin_i,
  input wire logic pointer_clock_pin_i,
  input wire logic pointer_data_pin_i,
  input wire logic keypad_clock_pin_i,
  input wire logic keypad_data_pin_i,
  input wire logic secondary_master_select_n_i,
  input wire logic secondary_slave_select_n_i,
  input wire logic [2:0] sec_addr_strap_i,
  input wire logic speaker_out_i,
  input wire logic keypad_ctrl_select_n_i,
  // Pin drivers
  output sbpm_pkg::sbpm_pad_t pointer_clock_pin_o,
  output sbpm_pkg::sbpm_pad_t pointer_data_pin_o,
  output sbpm_pkg::sbpm_pad_t keypad_clock_pin_o,
  output sbpm_pkg::sbpm_pad_t keypad_data_pin_o,
  output sbpm_pkg::sbpm_pad_t [3:0] extra_pci_interrupt_o,
  output sbpm_pkg::sbpm_pad_t [1:0] audio_serial_in_o,
  output sbpm_pkg::sbpm_pad_t [3:0] od_pin_o,
  output sbpm_pkg::sbpm_pad_t [1:0] second_smbus_o,
  output sbpm_pkg::sbpm_pad_t keypad_ctrl_select_n_o,
  output sbpm_pkg::sbpm_pad_t speaker_out_o,
  output logic pci_bus_reset_n_o,
  // Internal consumers
  output logic irq1_o,
  output logic irq12_o,
  output logic ptr_clk_o,
  output logic ptr_data_o,
  output logic kp_clk_o,
  output logic kp_data_o,
  output logic address_line_20_gate_o,
  output logic cpu_reset_o,
  output logic sixth_bus_request_n_o,
  output logic [3:0] extra_irq_n_o,
  output logic [1:0] audio_serial_o,
  output logic [1:0] smb2_in_o,
  // Status
  output logic [31:0] gpi_value_o,
  output logic [15:0] pm_status_o,
  output logic [7:0] chg_status_o,
  output logic sci_o,
  output logic smi_o,
  output sbpm_pkg::sbpm_strap_t strap_o,
  output logic strap_valid_o
);

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic [sbpm_pkg::SYNC_W-1:0] raw;
  logic [sbpm_pkg::SYNC_W-1:0] s1_q;
  logic [sbpm_pkg::SYNC_W-1:0] s2_q;
  logic [sbpm_pkg::SYNC_W-1:0] s3_q;
  logic [sbpm_pkg::SYNC_W-1:0] pin_q;
  logic [sbpm_pkg::SYNC_W-1:0] pin_d;

  assign raw = {general_input_aux_i, keypad_ctrl_select_n_i, speaker_out_i,
                sec_addr_strap_i, secondary_slave_select_n_i,
                secondary_master_select_n_i, keypad_data_pin_i, keypad_clock_pin_i,
                pointer_data_pin_i, pointer_clock_pin_i, general_input_hi_i,
                second_smbus_clock_pin_i, second_smbus_data_pin_i, od_pin_i,
                audio_serial_in_i, thermal_alarm_n_i, extra_pci_interrupt_n_i,
                sixth_bus_request_n_i, general_input_i};

  // Level only moves once the last two stages agree
  genvar g;
  generate
    for (g = 0; g < sbpm_pkg::SYNC_W; g++)
    begin : g_sync
      assign pin_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : pin_q[g];
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      pin_q <= '1;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  // ****************************************************
  // Strap capture
  // ****************************************************
  // Wait for the synchronisers to fill before trusting straps
  // Straps read the agreed level, which pin_q only takes on this edge
  logic [1:0] wait_q;
  logic strap_vld_q;
  sbpm_pkg::sbpm_strap_t strap_q;
  wire strap_take = !strap_vld_q && (wait_q == sbpm_pkg::STRAP_WAIT_CYC);

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wait_q <= 2'h0;
      strap_vld_q <= 1'b0;
      strap_q <= '0;
    end
    else
    begin
      if (!strap_take && !strap_vld_q)
        wait_q <= wait_q + 2'h1;
      if (strap_take)
        strap_vld_q <= 1'b1;
      if (strap_take)
      begin
        // pulled low means EEPROM via management bus
        strap_q.eeprom_mgmt <= !pin_d[sbpm_pkg::IX_SMSEL];
        // keyboard select high enables LPC BIOS ROM
        strap_q.lpc_bios_en <= pin_d[sbpm_pkg::IX_KCS];
        strap_q.cpu_freq_en <= !pin_d[sbpm_pkg::IX_SPEAKER_OUT];
        // secondary slave on bit 3, address on 2:0
        strap_q.link_data <= {pin_d[sbpm_pkg::IX_SSSEL], pin_d[sbpm_pkg::IX_SADDR+2],
                              pin_d[sbpm_pkg::IX_SADDR+1], pin_d[sbpm_pkg::IX_SADDR]};
      end
    end
  end

  // ****************************************************
  // Function selection per shared pin
  // ****************************************************
  wire xint_gp_in = !cfg_i.gpo_int_sel && !cfg_i.extra_int_en;
  wire xint_gp_out = cfg_i.gpo_int_sel && !cfg_i.extra_int_en;
  wire xint_irq = cfg_i.extra_int_en;
  wire [1:0] pcs_en = {cfg_i.prog_select_1_n_en, cfg_i.prog_select_0_n_en};
  wire smb2_gp = cfg_i.smb2_dis;
  wire [3:0] od_state = {gpo_state_i[29], gpo_state_i[28], gpo_state_i[23], gpo_state_i[22]};
  wire [3:0] od_pins = pin_q[sbpm_pkg::IX_OD +: 4];
  wire [1:0] aud_pins = pin_q[sbpm_pkg::IX_AUD +: 2];
  wire [3:0] xint_pins = pin_q[sbpm_pkg::IX_XINT +: 4];
  wire [1:0] smb_pins = {pin_q[sbpm_pkg::IX_SMBC], pin_q[sbpm_pkg::IX_SMBD]};
  wire [1:0] smb_state = {gpo_state_i[27], gpo_state_i[26]};

  sbpm_pkg::sbpm_pad_t ptr_clk_pd;
  sbpm_pkg::sbpm_pad_t ptr_dat_pd;
  sbpm_pkg::sbpm_pad_t kp_clk_pd;
  sbpm_pkg::sbpm_pad_t kp_dat_pd;
  sbpm_pkg::sbpm_pad_t kcs_pd;
  sbpm_pkg::sbpm_pad_t spk_pd;
  sbpm_pkg::sbpm_pad_t [3:0] xint_pd;
  sbpm_pkg::sbpm_pad_t [1:0] aud_pd;
  sbpm_pkg::sbpm_pad_t [3:0] od_pd;
  sbpm_pkg::sbpm_pad_t [1:0] smb_pd;

  // mouse lines are open drain from the internal controller
  assign ptr_clk_pd = '{out: 1'b0, oe: cfg_i.mouse_sel && ptr_clk_drv_i};
  assign ptr_dat_pd = '{out: 1'b0, oe: cfg_i.mouse_sel && ptr_data_drv_i};
  // in external keyboard mode these pins are inputs only
  assign kp_clk_pd = '{out: 1'b0, oe: cfg_i.kbc_en && kp_clk_drv_i};
  assign kp_dat_pd = '{out: 1'b0, oe: cfg_i.kbc_en && kp_data_drv_i};
  // select driven only once straps are taken
  assign kcs_pd = '{out: ext_kbc_select_n_i, oe: strap_vld_q && !cfg_i.kbc_en};
  // Speaker pin stays released while its strap is sampled
  assign spk_pd = '{out: speaker_i, oe: strap_vld_q};

  generate
    for (g = 0; g < 4; g++)
    begin : g_xint
      assign xint_pd[g] = '{out: gpo_state_i[12+g], oe: xint_gp_out};
      // low only while the state bit is 0, else released
      assign od_pd[g] = '{out: 1'b0, oe: cfg_i.od_grp_sel && !od_state[g]};
    end
    for (g = 0; g < 2; g++)
    begin : g_pair
      // chip select pushes; output bit 1 releases the pin
      assign aud_pd[g] = '{out: pcs_en[g] && cfg_i.audio_gp_sel && pcs_n_i[g],
                           oe: cfg_i.audio_gp_sel && (pcs_en[g] || !gpo_state_i[20+g])};
      // SMBus pins as open-drain outputs when enabled
      assign smb_pd[g] = '{out: 1'b0,
                           oe: smb2_gp ? (cfg_i.smb2_oe && !smb_state[g])
                                       : (g ? smb2_clk_drv_i : smb2_data_drv_i)};
    end
  endgenerate

  // ****************************************************
  // General input word
  // ****************************************************
  logic [31:0] gpi_d;
  always_comb
  begin
    gpi_d = '0;
    gpi_d[6:0] = pin_q[sbpm_pkg::IX_GI0 +: 7];
    // request pin reads as input 7 only when not a request
    gpi_d[7] = !cfg_i.req6_sel && pin_q[sbpm_pkg::IX_REQ6];
    // inputs 12 to 15 when both select bits clear
    gpi_d[15:12] = xint_gp_in ? xint_pins : 4'h0;
    gpi_d[17:16] = pin_q[sbpm_pkg::IX_GI16 +: 2];
    // thermal pin is input 18 when thermal function off
    gpi_d[18] = !cfg_i.thermal_en && pin_q[sbpm_pkg::IX_THERM];
    gpi_d[19] = pin_q[sbpm_pkg::IX_AUX];
    gpi_d[25:24] = pin_q[sbpm_pkg::IX_AUX+1 +: 2];
    // inputs 20 and 21 when selected without chip select
    gpi_d[21:20] = aud_pins & ~pcs_en & {2{cfg_i.audio_gp_sel}} & gpo_state_i[21:20];
    // group inputs valid only with driver released
    gpi_d[23:22] = od_pins[1:0] & od_state[1:0] & {2{cfg_i.od_grp_sel}};
    gpi_d[29:28] = od_pins[3:2] & od_state[3:2] & {2{cfg_i.od_grp_sel}};
    // SMBus pins read as 26 and 27 with output off
    gpi_d[27:26] = smb_pins & {2{smb2_gp && !cfg_i.smb2_oe}};
  end

  // dedicated inputs placed into status bits
  logic [15:0] pm_d;
  always_comb
  begin
    pm_d = '0;
    pm_d[sbpm_pkg::ST_GI0] = gpi_d[0];
    pm_d[sbpm_pkg::ST_GI1] = gpi_d[1];
    pm_d[sbpm_pkg::ST_GI2] = gpi_d[2];
    pm_d[sbpm_pkg::ST_GI3] = gpi_d[3];
    pm_d[sbpm_pkg::ST_GI4] = gpi_d[4];
    pm_d[sbpm_pkg::ST_GI5] = gpi_d[5];
    pm_d[sbpm_pkg::ST_GI6_17] = gpi_d[6] | gpi_d[17];
    pm_d[sbpm_pkg::ST_GI16] = gpi_d[16];
  end

  // ****************************************************
  // Change status
  // ****************************************************
  function automatic logic [7:0] chg_pick(input logic [31:0] v);
    chg_pick = {v[27:24], v[19:16]};
  endfunction

  logic [7:0] prev_q;
  logic [7:0] chg_q;
  // One edge after capture, so the preset level never reads as a change
  wire [7:0] chg_hit = strap_valid_o ? (chg_pick(gpi_d) ^ prev_q) : 8'h00;
  // a new change beats a clear in the same cycle
  wire [7:0] chg_d = chg_hit | (chg_q & ~chg_clr_i);

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prev_q <= sbpm_pkg::CHG_RST;
      chg_q <= sbpm_pkg::CHG_RST;
    end
    else
    begin
      prev_q <= chg_pick(gpi_d);
      chg_q <= chg_d;
    end
  end

  // ****************************************************
  // Registered outputs
  // ****************************************************
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pointer_clock_pin_o <= '0;
      pointer_data_pin_o <= '0;
      keypad_clock_pin_o <= '0;
      keypad_data_pin_o <= '0;
      extra_pci_interrupt_o <= '0;
      audio_serial_in_o <= '0;
      od_pin_o <= '0;
      second_smbus_o <= '0;
      keypad_ctrl_select_n_o <= '0;
      speaker_out_o <= '0;
      pci_bus_reset_n_o <= 1'b0;
      irq1_o <= 1'b0;
      irq12_o <= 1'b0;
      ptr_clk_o <= 1'b1;
      ptr_data_o <= 1'b1;
      kp_clk_o <= 1'b1;
      kp_data_o <= 1'b1;
      address_line_20_gate_o <= 1'b0;
      cpu_reset_o <= 1'b0;
      sixth_bus_request_n_o <= 1'b1;
      extra_irq_n_o <= 4'hF;
      audio_serial_o <= 2'h0;
      smb2_in_o <= 2'h3;
      gpi_value_o <= sbpm_pkg::GPI_RST;
      pm_status_o <= '0;
      chg_status_o <= sbpm_pkg::CHG_RST;
      sci_o <= 1'b0;
      smi_o <= 1'b0;
      strap_o <= '0;
      strap_valid_o <= 1'b0;
    end
    else
    begin
      pointer_clock_pin_o <= ptr_clk_pd;
      pointer_data_pin_o <= ptr_dat_pd;
      keypad_clock_pin_o <= kp_clk_pd;
      keypad_data_pin_o <= kp_dat_pd;
      extra_pci_interrupt_o <= xint_pd;
      audio_serial_in_o <= aud_pd;
      od_pin_o <= od_pd;
      second_smbus_o <= smb_pd;
      keypad_ctrl_select_n_o <= kcs_pd;
      speaker_out_o <= spk_pd;
      // held low through reset and on software request
      pci_bus_reset_n_o <= !pci_reset_req_i;
      // mouse mode feeds controller, else interrupt inputs
      irq1_o <= !cfg_i.mouse_sel && pin_q[sbpm_pkg::IX_PCLK];
      irq12_o <= !cfg_i.mouse_sel && pin_q[sbpm_pkg::IX_PDAT];
      ptr_clk_o <= !cfg_i.mouse_sel || pin_q[sbpm_pkg::IX_PCLK];
      ptr_data_o <= !cfg_i.mouse_sel || pin_q[sbpm_pkg::IX_PDAT];
      kp_clk_o <= !cfg_i.kbc_en || pin_q[sbpm_pkg::IX_KCLK];
      kp_data_o <= !cfg_i.kbc_en || pin_q[sbpm_pkg::IX_KDAT];
      // external controller drives gate-A20 high and reset low
      address_line_20_gate_o <= !cfg_i.kbc_en && pin_q[sbpm_pkg::IX_KCLK];
      cpu_reset_o <= !cfg_i.kbc_en && !pin_q[sbpm_pkg::IX_KDAT];
      sixth_bus_request_n_o <= !cfg_i.req6_sel || pin_q[sbpm_pkg::IX_REQ6];
      extra_irq_n_o <= xint_irq ? xint_pins : 4'hF;
      // audio inputs when select and enables clear, bits high
      audio_serial_o <= aud_pins & ~pcs_en & {2{!cfg_i.audio_gp_sel}} & gpo_state_i[21:20];
      smb2_in_o <= smb2_gp ? 2'h3 : smb_pins;
      // all 26 inputs as one 32-bit word
      gpi_value_o <= gpi_d;
      pm_status_o <= pm_d;
      chg_status_o <= chg_d;
      // routing bit 1 sends the change to SMI
      sci_o <= |(chg_d & ~chg_route_smi_i);
      smi_o <= |(chg_d & chg_route_smi_i);
      strap_o <= strap_q;
      strap_valid_o <= strap_vld_q;
    end
  end

endmodule

// ===== sbpm_pkg.sv
// Shared constants and carrier types for the south bridge pin function mux
package sbpm_pkg;

  // ****************************************************
  // Synchroniser slot of each sampled pin
  // ****************************************************
  localparam int SYNC_W = 37;
  localparam int IX_GI0 = 0;
  localparam int IX_REQ6 = 7;
  localparam int IX_XINT = 8;
  localparam int IX_THERM = 12;
  localparam int IX_AUD = 13;
  localparam int IX_OD = 15;
  localparam int IX_SMBD = 19;
  localparam int IX_SMBC = 20;
  localparam int IX_GI16 = 21;
  localparam int IX_PCLK = 23;
  localparam int IX_PDAT = 24;
  localparam int IX_KCLK = 25;
  localparam int IX_KDAT = 26;
  localparam int IX_SMSEL = 27;
  localparam int IX_SSSEL = 28;
  localparam int IX_SADDR = 29;
  localparam int IX_SPEAKER_OUT = 32;
  localparam int IX_KCS = 33;
  localparam int IX_AUX = 34;

  // ****************************************************
  // Status bit positions and reset values
  // ****************************************************
  localparam int ST_GI0 = 0;
  localparam int ST_GI1 = 1;
  localparam int ST_GI2 = 4;
  localparam int ST_GI3 = 8;
  localparam int ST_GI4 = 11;
  localparam int ST_GI5 = 12;
  localparam int ST_GI6_17 = 5;
  localparam int ST_GI16 = 6;
  localparam logic [31:0] GPI_RST = 32'h0000_0000;
  localparam logic [7:0] CHG_RST = 8'h00;
  localparam logic [1:0] STRAP_WAIT_CYC = 2'h3;

  typedef struct packed {
    logic mouse_sel;
    logic kbc_en;
    logic req6_sel;
    logic gpo_int_sel;
    logic extra_int_en;
    logic thermal_en;
    logic audio_gp_sel;
    logic prog_select_0_n_en;
    logic prog_select_1_n_en;
    logic od_grp_sel;
    logic smb2_dis;
    logic smb2_oe;
  } sbpm_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
  } sbpm_pad_t;

  typedef struct packed {
    logic eeprom_mgmt;
    logic lpc_bios_en;
    logic cpu_freq_en;
    logic [3:0] link_data;
  } sbpm_strap_t;

endpackage

// ===== sbpm_board.sv
// Board side model: external drivers, pull-ups and strap resistors
`timescale 1ns/1ps
module sbpm_board #(
  parameter logic [6:0] STRAP = 7'h4D
) (
  // Device pads
  input wire sbpm_pkg::sbpm_pad_t [15:0] pad_i,
  input wire sbpm_pkg::sbpm_pad_t [1:0] strap_pad_i,
  // External levels, 1 = released to pull-up
  input wire logic [15:0] ext_i,
  // Resolved pins
  output logic [15:0] pin_o,
  output logic [6:0] strap_o
);
  // Wired-AND: a released line never keeps a stale level
  for (genvar i = 0; i < 16; i++)
  begin : g_pin
    assign pin_o[i] = pad_i[i].oe ? (pad_i[i].out & ext_i[i]) : ext_i[i];
  end
  // strap resistors hold levels while released
  assign strap_o[6] = strap_pad_i[1].oe ? strap_pad_i[1].out : STRAP[6];
  assign strap_o[5] = strap_pad_i[0].oe ? strap_pad_i[0].out : STRAP[5];
  assign strap_o[4:0] = STRAP[4:0];
endmodule

// ===== sbpm_mux_monitor.sv
// Port assertions for the pin function mux
`timescale 1ns/1ps
module sbpm_mux_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Controls
  input wire sbpm_pkg::sbpm_cfg_t cfg_i,
  input wire logic [31:0] gpo_state_i,
  input wire logic pci_reset_req_i,
  input wire logic ext_kbc_select_n_i,
  input wire logic [1:0] pcs_n_i,
  // Outputs watched
  input wire sbpm_pkg::sbpm_pad_t keypad_ctrl_select_n_o,
  input wire sbpm_pkg::sbpm_pad_t [3:0] extra_pci_interrupt_o,
  input wire sbpm_pkg::sbpm_pad_t [1:0] audio_serial_in_o,
  input wire sbpm_pkg::sbpm_pad_t [3:0] od_pin_o,
  input wire sbpm_pkg::sbpm_pad_t [1:0] second_smbus_o,
  input wire logic pci_bus_reset_n_o,
  input wire logic irq1_o,
  input wire logic irq12_o,
  input wire logic [31:0] gpi_value_o,
  input wire logic [15:0] pm_status_o,
  input wire sbpm_pkg::sbpm_strap_t strap_o,
  input wire logic strap_valid_o
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_mouse;
    $past(cfg_i.mouse_sel) |-> !irq1_o && !irq12_o;
  endproperty
  a_mouse: assert property (p_mouse) else $error("irq live in mouse mode");
  property p_kbsel;
    $past(!cfg_i.kbc_en && strap_valid_o) |-> keypad_ctrl_select_n_o.oe &&
      keypad_ctrl_select_n_o.out == $past(ext_kbc_select_n_i);
  endproperty
  a_kbsel: assert property (p_kbsel) else $error("controller select not driven");
  property p_status;
    pm_status_o[0] == gpi_value_o[0] && pm_status_o[4] == gpi_value_o[2] &&
      pm_status_o[12] == gpi_value_o[5] && pm_status_o[6] == gpi_value_o[16];
  endproperty
  a_status: assert property (p_status) else $error("status bit mismatch");
  property p_gate;
    $past(cfg_i.req6_sel) || $past(cfg_i.thermal_en) |->
      !($past(cfg_i.req6_sel) && gpi_value_o[7]) && !($past(cfg_i.thermal_en) && gpi_value_o[18]);
  endproperty
  a_gate: assert property (p_gate) else $error("gated input reads high");
  property p_xout;
    $past(arst_n_i && cfg_i.gpo_int_sel && !cfg_i.extra_int_en) |->
      extra_pci_interrupt_o[2].oe && extra_pci_interrupt_o[2].out == $past(gpo_state_i[14]);
  endproperty
  a_xout: assert property (p_xout) else $error("output 14 wrong");
  property p_xin;
    $past(!cfg_i.gpo_int_sel) |-> !extra_pci_interrupt_o[1].oe;
  endproperty
  a_xin: assert property (p_xin) else $error("input pin driven");
  property p_csel;
    $past(arst_n_i && cfg_i.audio_gp_sel && cfg_i.prog_select_1_n_en) |->
      audio_serial_in_o[1].oe && audio_serial_in_o[1].out == $past(pcs_n_i[1]);
  endproperty
  a_csel: assert property (p_csel) else $error("chip select 1 wrong");
  property p_odlow;
    $past(arst_n_i && cfg_i.od_grp_sel && !gpo_state_i[22]) |-> od_pin_o[0].oe && !od_pin_o[0].out;
  endproperty
  a_odlow: assert property (p_odlow) else $error("open drain 22 not low");
  property p_smbin;
    $past(cfg_i.smb2_dis && !cfg_i.smb2_oe) |-> !second_smbus_o[0].oe && !second_smbus_o[1].oe;
  endproperty
  a_smbin: assert property (p_smbin) else $error("bus pins driven");
  property p_pci_bus_reset_n;
    $past(arst_n_i) |-> pci_bus_reset_n_o == !$past(pci_reset_req_i);
  endproperty
  a_pci_bus_reset_n: assert property (p_pci_bus_reset_n) else $error("bus reset wrong");
  property p_strap;
    strap_valid_o |=> strap_valid_o && $stable(strap_o);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not held");
  c_strap: cover property ($rose(strap_valid_o));
  c_pci_bus_reset_n: cover property (pci_reset_req_i ##1 !pci_bus_reset_n_o);
  c_xout: cover property (extra_pci_interrupt_o[0].oe);
endmodule

bind sbpm_mux sbpm_mux_chk u_chk (
  .mclk_i, .arst_n_i, .cfg_i, .gpo_state_i, .pci_reset_req_i, .ext_kbc_select_n_i, .pcs_n_i,
  .keypad_ctrl_select_n_o, .extra_pci_interrupt_o, .audio_serial_in_o, .od_pin_o,
  .second_smbus_o, .pci_bus_reset_n_o, .irq1_o, .irq12_o, .gpi_value_o, .pm_status_o,
  .strap_o, .strap_valid_o
);

// ===== tb_top.sv
// Self-checking testbench for the pin function mux
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  sbpm_pkg::sbpm_cfg_t cfg_i = 12'h400;
  logic [31:0] gpo_state_i = 32'hFFFF_FFFF;
  logic pci_reset_req_i = 1'b0;
  logic [7:0] chg_route_smi_i = 8'h00;
  logic [7:0] chg_clr_i = 8'h00;
  logic [9:0] ctl = 10'h0D0;
  logic [31:0] p = 32'hFFFF_FFFF;
  logic [15:0] ext = 16'hFFFF;
  logic [15:0] pin;
  logic [6:0] strap;
  wire sbpm_pkg::sbpm_pad_t [15:0] pads;
  wire sbpm_pkg::sbpm_pad_t [1:0] spad;
  sbpm_pkg::sbpm_strap_t strap_o;
  logic irq1_o, irq12_o, ptr_clk_o, ptr_data_o, kp_clk_o, kp_data_o, address_line_20_gate_o;
  logic cpu_reset_o, sixth_bus_request_n_o, sci_o, smi_o, strap_valid_o, pci_bus_reset_n_o;
  logic [3:0] extra_irq_n_o;
  logic [1:0] audio_serial_o, smb2_in_o;
  logic [31:0] gpi_value_o;
  logic [15:0] pm_status_o;
  logic [7:0] chg_status_o;
  int err_count = 0;
  int total_checks = 0;

  always #50 mclk_i = ~mclk_i;

  sbpm_board #(.STRAP(7'h4D)) board (.pad_i(pads), .strap_pad_i(spad), .ext_i(ext),
    .pin_o(pin), .strap_o(strap));

  sbpm_mux DUT (
    .mclk_i, .arst_n_i, .cfg_i, .gpo_state_i, .pci_reset_req_i, .chg_route_smi_i, .chg_clr_i,
    .ptr_clk_drv_i(ctl[0]), .ptr_data_drv_i(ctl[1]), .kp_clk_drv_i(ctl[2]), .kp_data_drv_i(ctl[3]),
    .ext_kbc_select_n_i(ctl[4]), .speaker_i(ctl[5]), .pcs_n_i(ctl[7:6]),
    .smb2_data_drv_i(ctl[8]), .smb2_clk_drv_i(ctl[9]),
    .general_input_i(p[6:0]), .general_input_hi_i(p[17:16]),
    .general_input_aux_i({p[25], p[24], p[19]}), .sixth_bus_request_n_i(p[7]),
    .extra_pci_interrupt_n_i(pin[7:4]), .thermal_alarm_n_i(p[18]), .audio_serial_in_i(pin[9:8]),
    .od_pin_i(pin[13:10]), .second_smbus_data_pin_i(pin[14]), .second_smbus_clock_pin_i(pin[15]),
    .pointer_clock_pin_i(pin[0]), .pointer_data_pin_i(pin[1]), .keypad_clock_pin_i(pin[2]),
    .keypad_data_pin_i(pin[3]), .secondary_master_select_n_i(strap[4]),
    .secondary_slave_select_n_i(strap[3]), .sec_addr_strap_i(strap[2:0]),
    .speaker_out_i(strap[5]), .keypad_ctrl_select_n_i(strap[6]),
    .pointer_clock_pin_o(pads[0]), .pointer_data_pin_o(pads[1]), .keypad_clock_pin_o(pads[2]),
    .keypad_data_pin_o(pads[3]), .extra_pci_interrupt_o(pads[7:4]), .audio_serial_in_o(pads[9:8]),
    .od_pin_o(pads[13:10]), .second_smbus_o(pads[15:14]), .keypad_ctrl_select_n_o(spad[1]),
    .speaker_out_o(spad[0]), .pci_bus_reset_n_o, .irq1_o, .irq12_o, .ptr_clk_o, .ptr_data_o,
    .kp_clk_o, .kp_data_o, .address_line_20_gate_o, .cpu_reset_o, .sixth_bus_request_n_o,
    .extra_irq_n_o, .audio_serial_o, .smb2_in_o, .gpi_value_o, .pm_status_o, .chg_status_o,
    .sci_o, .smi_o, .strap_o, .strap_valid_o
  );

  // ********
  // Helpers
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_strap();
    int i;
    for (i = 0; i < 20; i++)
    begin
      if (strap_valid_o === 1'b1)
        break;
      step(1);
    end
    chk(strap_valid_o, 1'b1);
    if (i == 20)
      complete_run();
    chk(strap_o, 7'h7D);
    chk(pci_bus_reset_n_o, 1'b1);
    $display("test strap finished");
  endtask

  task automatic t_inputs(input logic [31:0] v);
    logic [15:0] e;
    e = 16'h0000;
    cfg_i = 12'h426;
    gpo_state_i = 32'hFFFF_FFFF;
    p = v;
    ext = {v[27:26], v[29:28], v[23:22], v[21:20], v[15:12], 4'hF};
    step(7);
    chk(gpi_value_o, v & 32'h3FFF_F0FF);
    {e[0], e[1], e[4], e[8], e[11], e[12], e[6]} = {v[0], v[1], v[2], v[3], v[4], v[5], v[16]};
    e[5] = v[6] | v[17];
    chk(pm_status_o & 16'h1973, e);
    $display("test inputs finished");
  endtask

  task automatic t_gate();
    cfg_i = 12'h767;
    gpo_state_i = 32'h38B0_A000;
    p = 32'hFFFF_FF7F;
    ext = 16'hFFFF;
    step(7);
    chk(gpi_value_o, 32'h33BB_007F);
    chk(sixth_bus_request_n_o, 1'b0);
    chk(pin[7:4], 4'hA);
    chk({pin[15:14], pin[11:10]}, 4'b1010);
    $display("test gating finished");
  endtask

  task automatic t_kbd();
    cfg_i = 12'hC00;
    ctl = 10'h0D1;
    step(7);
    chk({ptr_clk_o, ptr_data_o, kp_clk_o, kp_data_o, irq1_o, irq12_o}, 6'h1C);
    cfg_i = 12'h000;
    ctl = 10'h0C0;
    ext = 16'hFFF6;
    step(7);
    chk({irq1_o, irq12_o, address_line_20_gate_o, cpu_reset_o, strap[6]}, 5'h0E);
    $display("test keyboard finished");
  endtask

  task automatic t_chip_sel();
    cfg_i = 12'h438;
    ctl = 10'h050;
    ext = 16'hFFFF;
    step(3);
    chk(pin[9:8], 2'b01);
    cfg_i = 12'h400;
    ext = 16'hFEFF;
    step(7);
    chk({audio_serial_o, gpi_value_o[21:20]}, 4'b1000);
    $display("test chip select finished");
  endtask

  task automatic t_change();
    chg_route_smi_i = 8'h10;
    step(7);
    chg_clr_i = 8'hFF;
    step(1);
    chg_clr_i = 8'h00;
    p[16] = ~p[16];
    step(7);
    chk({chg_status_o, sci_o, smi_o}, 10'h006);
    p[24] = ~p[24];
    step(7);
    chk({chg_status_o, sci_o, smi_o}, 10'h047);
    chg_clr_i = 8'h01;
    step(1);
    chg_clr_i = 8'h00;
    step(1);
    chk(chg_status_o, 8'h10);
    $display("test change finished");
  endtask

  task automatic t_misc();
    pci_reset_req_i = 1'b1;
    step(2);
    chk(pci_bus_reset_n_o, 1'b0);
    pci_reset_req_i = 1'b0;
    ctl = 10'h1D0;
    step(2);
    chk(pci_bus_reset_n_o, 1'b1);
    chk(pin[15:14], 2'b10);
    cfg_i = 12'h480;
    ext = 16'hFF5F;
    step(7);
    chk({smb2_in_o, extra_irq_n_o}, 6'h25);
    arst_n_i = 1'b0;
    step(2);
    chk(pci_bus_reset_n_o, 1'b0);
    arst_n_i = 1'b1;
    t_strap();
    step(2);
    chk({chg_status_o, sci_o, smi_o}, 10'h000);
    $display("test misc finished");
  endtask

  initial
  begin
    step(10);
    chk(pci_bus_reset_n_o, 1'b0);
    arst_n_i = 1'b1;
    t_strap();
    t_inputs(32'hA5A5_5A5A);
    t_inputs(32'h5A5A_A5A5);
    t_gate();
    t_kbd();
    t_chip_sel();
    t_change();
    t_misc();
    complete_run();
  end
endmodule
